/* File: src/lgoc_cfg.svh */
// offsets, reset values and widths for the channel output control block
`ifndef LGOC_CFG_SVH
`define LGOC_CFG_SVH

`define LGOC_ADDR_LVL_UPPER   8'h02
`define LGOC_ADDR_LVL_LOWER   8'h03
`define LGOC_ADDR_DIR_UPPER   8'h04
`define LGOC_ADDR_DIR_LOWER   8'h05
`define LGOC_ADDR_FSEL_UPPER  8'h12
`define LGOC_ADDR_FSEL_LOWER  8'h13
`define LGOC_ADDR_BREATH      8'h14

`define LGOC_UPPER_W          6
`define LGOC_LOWER_W          4
`define LGOC_BREATH_W         6
`define LGOC_CHAN_N           10

`define LGOC_DIR_UPPER_RST    6'h00
`define LGOC_DIR_LOWER_RST    4'h0
`define LGOC_FSEL_UPPER_RST   6'h3F
`define LGOC_FSEL_LOWER_RST   4'hF
`define LGOC_BREATH_RST       6'h00
`define LGOC_RD_UNMAPPED      8'h00

`endif

/* File: src/lgoc_pkg.sv */
// types shared by the channel output control block
package lgoc_pkg;

  // one register access from the serial interface front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lgoc_req_t;

  // ramp trigger pulses for the six breathing-capable channels
  typedef struct packed {
    logic [5:0] on;
    logic [5:0] off;
  } lgoc_fade_t;

endpackage

/* File: src/lgoc_gpio_ctrl.sv */
// channel output level, direction and ramp trigger logic for the ten driver channels
//
// Behaviour
// - upper level bits 5..2 drive channels nine..six low for 0, high for 1
// - channel five in gpio use: upper level bit 1 sets pin low/high
// - channel five led+breathing: bit 1 rise starts fade-on, fall starts fade-off
// - channel four in gpio use: upper level bit 0 sets pin low/high
// - channel four led+breathing: bit 0 rise triggers fade-on, fall fade-off
// - channels zero..three in gpio use: lower level bits 0..3 drive pins
// - channels zero..three led+breathing: lower bit rise fade-on, fall fade-off
// - upper direction bits 5..2: channels nine..six output for 0, input for 1
// - channel eight direction bit resets to 0, an output
// - channel five gpio use: direction bit 1 output for 0, input for 1
// - channel five led+breathing: direction bit 1 ramp for 0, flash for 1
// - channel four gpio use: direction bit 0 output/input, resets to 0
// - channel four led+breathing: direction bit 0 ramp for 0, flash for 1
// - function select 0 means led use, 1 gpio use; resets to 1
// - channels zero..three led+breathing: lower direction bit ramp 0, flash 1
`timescale 1ns/100ps
`include "lgoc_cfg.svh"

module lgoc_gpio_ctrl
  import lgoc_pkg::*;
(
  input  wire logic                     mclk,           // 20 MHz block clock
  input  wire logic                     rst_n,          // synchronous reset, active low
  input  wire lgoc_req_t                regReq,         // register access from serial front end
  output logic      [7:0]               regRdData,      // read data, valid cycle after rd
  input  wire logic                     addrSelPin0,    // address-select strap 0
  input  wire logic                     addrSelPin1,    // address-select strap 1
  output logic      [`LGOC_CHAN_N-1:0]  pinOut,         // per-channel pin level
  output logic      [`LGOC_CHAN_N-1:0]  pinOeN,         // per-channel drive enable, low drives
  output logic      [`LGOC_CHAN_N-1:0]  ledMode,        // channel handed to led driver
  output logic      [`LGOC_BREATH_W-1:0] flashSel,      // periodic flash chosen, per channel
  output lgoc_fade_t                    fade            // one-cycle ramp start pulses
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [`LGOC_UPPER_W-1:0]  lvlUpper;
  logic [`LGOC_LOWER_W-1:0]  lvlLower;
  logic [`LGOC_UPPER_W-1:0]  dirUpper;
  logic [`LGOC_LOWER_W-1:0]  dirLower;
  logic [`LGOC_UPPER_W-1:0]  fselUpper;
  logic [`LGOC_LOWER_W-1:0]  fselLower;
  logic [`LGOC_BREATH_W-1:0] breathEn;

  logic [`LGOC_CHAN_N-1:0]   levelVec;
  logic [`LGOC_CHAN_N-1:0]   dirVec;
  logic [`LGOC_CHAN_N-1:0]   fselVec;
  logic [`LGOC_BREATH_W-1:0] breathLed;
  logic                      wrLvlUpper;
  logic                      wrLvlLower;
  logic [`LGOC_BREATH_W-1:0] next_oldLvl;
  logic [`LGOC_BREATH_W-1:0] next_newLvl;
  logic [`LGOC_BREATH_W-1:0] next_hit;

  // channel-ordered views: lower bank holds channels 0..3, upper 4..9
  assign levelVec  = {lvlUpper, lvlLower};
  assign dirVec    = {dirUpper, dirLower};
  assign fselVec   = {fselUpper, fselLower};
  assign breathLed = breathEn & ~fselVec[`LGOC_BREATH_W-1:0];

  assign wrLvlUpper = regReq.wr && (regReq.addr == `LGOC_ADDR_LVL_UPPER);
  assign wrLvlLower = regReq.wr && (regReq.addr == `LGOC_ADDR_LVL_LOWER);

  ////////////////////////////////////////////////////////////////////////////
  // level registers; reset follows the straps, caught at the clock edge
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      lvlUpper <= {`LGOC_UPPER_W{addrSelPin1}};
      lvlLower <= {`LGOC_LOWER_W{addrSelPin0}};
    end
    else
    begin
      if (wrLvlUpper)
        lvlUpper <= regReq.wdata[`LGOC_UPPER_W-1:0];
      if (wrLvlLower)
        lvlLower <= regReq.wdata[`LGOC_LOWER_W-1:0];
    end
  end

  // direction / effect and mode registers; upper data bits are dropped
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      dirUpper  <= `LGOC_DIR_UPPER_RST;
      dirLower  <= `LGOC_DIR_LOWER_RST;
      fselUpper <= `LGOC_FSEL_UPPER_RST;
      fselLower <= `LGOC_FSEL_LOWER_RST;
      breathEn  <= `LGOC_BREATH_RST;
    end
    else if (regReq.wr)
    begin
      if (regReq.addr == `LGOC_ADDR_DIR_UPPER)
        dirUpper <= regReq.wdata[`LGOC_UPPER_W-1:0];
      else if (regReq.addr == `LGOC_ADDR_DIR_LOWER)
        dirLower <= regReq.wdata[`LGOC_LOWER_W-1:0];
      else if (regReq.addr == `LGOC_ADDR_FSEL_UPPER)
        fselUpper <= regReq.wdata[`LGOC_UPPER_W-1:0];
      else if (regReq.addr == `LGOC_ADDR_FSEL_LOWER)
        fselLower <= regReq.wdata[`LGOC_LOWER_W-1:0];
      else if (regReq.addr == `LGOC_ADDR_BREATH)
        breathEn <= regReq.wdata[`LGOC_BREATH_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port; unmapped addresses answer zero
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      regRdData <= `LGOC_RD_UNMAPPED;
    else if (regReq.rd)
    begin
      if (regReq.addr == `LGOC_ADDR_LVL_UPPER)
        regRdData <= {2'h0, lvlUpper};
      else if (regReq.addr == `LGOC_ADDR_LVL_LOWER)
        regRdData <= {4'h0, lvlLower};
      else if (regReq.addr == `LGOC_ADDR_DIR_UPPER)
        regRdData <= {2'h0, dirUpper};
      else if (regReq.addr == `LGOC_ADDR_DIR_LOWER)
        regRdData <= {4'h0, dirLower};
      else if (regReq.addr == `LGOC_ADDR_FSEL_UPPER)
        regRdData <= {2'h0, fselUpper};
      else if (regReq.addr == `LGOC_ADDR_FSEL_LOWER)
        regRdData <= {4'h0, fselLower};
      else if (regReq.addr == `LGOC_ADDR_BREATH)
        regRdData <= {2'h0, breathEn};
      else
        regRdData <= `LGOC_RD_UNMAPPED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ramp edge detect: old and new level of breathing channels 0..5
  always_comb
  begin
    next_oldLvl = levelVec[`LGOC_BREATH_W-1:0];
    next_newLvl = next_oldLvl;
    if (wrLvlLower)
      next_newLvl[3:0] = regReq.wdata[3:0];
    if (wrLvlUpper)
      next_newLvl[5:4] = regReq.wdata[1:0];
    // a rewrite of the same value is not an edge
    next_hit = (next_oldLvl ^ next_newLvl) & breathLed;
  end

  // pulses last one cycle; the timers outside latch them
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      fade <= '0;
    else
    begin
      fade.on  <= next_hit & next_newLvl;
      fade.off <= next_hit & ~next_newLvl;
    end
  end

  // effect select only means something in led use with breathing on
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      flashSel <= '0;
    else
      flashSel <= dirVec[`LGOC_BREATH_W-1:0] & breathLed;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel pin drive; led-use channels are left to the current sink
  for (genvar ch = 0; ch < `LGOC_CHAN_N; ch++)
  begin : g_chan
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
      begin
        pinOut[ch]  <= 1'b0;
        pinOeN[ch]  <= 1'b1;
        ledMode[ch] <= 1'b0;
      end
      else
      begin
        pinOut[ch]  <= fselVec[ch] & levelVec[ch];
        pinOeN[ch]  <= ~(fselVec[ch] & ~dirVec[ch]);
        ledMode[ch] <= ~fselVec[ch];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_pin_level: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> pinOut == $past(levelVec & fselVec))
    else $error("pin level does not follow level register");

  a_pin_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> pinOeN == $past(~(fselVec & ~dirVec)))
    else $error("pin drive enable does not follow direction");

  a_fade_rise: assert property (@(posedge mclk) disable iff (!rst_n)
    wrLvlUpper && !lvlUpper[0] && regReq.wdata[0] && !fselUpper[0] && breathEn[4]
    |=> fade.on[4] && !fade.off[4])
    else $error("channel four fade-on missing");

  a_fade_fall: assert property (@(posedge mclk) disable iff (!rst_n)
    wrLvlLower && lvlLower[0] && !regReq.wdata[0] && !fselLower[0] && breathEn[0]
    |=> fade.off[0] ##1 !fade.off[0])
    else $error("channel zero fade-off missing or long");

  a_fade_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    !regReq.wr |=> fade.on == 6'h00 && fade.off == 6'h00)
    else $error("ramp pulse without a write");

  a_effect_sel: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> flashSel == $past(dirVec[5:0] & breathEn & ~fselVec[5:0]))
    else $error("effect select wrong");

  a_reset_vals: assert property (@(posedge mclk)
    !rst_n |=> dirUpper == 6'h00 && fselVec == 10'h3FF && pinOeN == 10'h3FF)
    else $error("reset values wrong");

  a_strap_reset: assert property (@(posedge mclk)
    !rst_n |=> lvlUpper == {6{$past(addrSelPin1)}} && lvlLower == {4{$past(addrSelPin0)}})
    else $error("level reset does not follow straps");

  a_unused_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    regReq.rd && regReq.addr == `LGOC_ADDR_LVL_LOWER |=> regRdData[7:4] == 4'h0)
    else $error("unused bits read nonzero");

endmodule // lgoc_gpio_ctrl

/* File: testbench/lgoc_host_model.sv */
// register host model issuing single-cycle accesses on the falling edge
`timescale 1ns/100ps
module lgoc_host_model
  import lgoc_pkg::*;
(
  input  wire logic       mclk,       // block clock
  input  wire logic [7:0] regRdData,  // read data from the block
  output lgoc_req_t       regReq      // one access per request cycle
);
////////////////////////////////////////
  // idle bus starts at zero, then carries inverted address and data so stale values never match
  initial regReq = '0;
  // write held across exactly one rising edge, then released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regReq <= '{1'b1, 1'b0, a, d};
    @(negedge mclk);
    regReq <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // read: data holds until the next read, so it is taken a full cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    regReq <= '{1'b0, 1'b1, a, 8'hA5};
    @(negedge mclk);
    regReq <= '{1'b0, 1'b0, ~a, 8'h5A};
    @(negedge mclk);
    d = regRdData;
  endtask
  // the flash-start control lives outside this block; its place here is a free choice
  localparam logic [7:0] FLASH_CTL_ADDR = 8'h7E;
  // periodic flash only runs once the host sets the start bit
  task automatic start_flash();
    wr(FLASH_CTL_ADDR, 8'h80);
  endtask
endmodule // lgoc_host_model

/* File: testbench/lgoc_gpio_ctrl_tb_top.sv */
// self-checking bench for the channel output control block
`timescale 1ns/100ps
module lgoc_gpio_ctrl_tb_top
  import lgoc_pkg::*;
;
  logic             mclk = 1'b0;   // 20 MHz clock
  logic             rst_n = 1'b0;  // synchronous reset
  logic             s0, s1;        // address straps
  lgoc_req_t        regReq;        // register access
  logic [7:0]       regRdData;     // read data
  logic [9:0]       pinOut, pinOeN, ledMode;
  logic [5:0]       flashSel;      // flash effect per channel
  lgoc_fade_t       fade;          // ramp pulses
  int               num_errors = 0;
  int               check_count = 0;
////////////////////////////////////////
  always #25 mclk = ~mclk;
  lgoc_gpio_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
    .addrSelPin0(s0), .addrSelPin1(s1), .pinOut(pinOut), .pinOeN(pinOeN), .ledMode(ledMode),
    .flashSel(flashSel), .fade(fade));
  lgoc_host_model i_host (.mclk(mclk), .regRdData(regRdData), .regReq(regReq));
////////////////////////////////////////
  // compare, count, report at once
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // expected ramp pulses {on, off} from old level, new level and breathing enables
  function automatic logic [11:0] fade_exp(input logic [5:0] was, input logic [5:0] now, input logic [5:0] en);
    return {now & ~was & en, ~now & was & en};
  endfunction
  // the whole run is under two hundred cycles; this cuts a hang short
  initial
  begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    end_sim();
  end
////////////////////////////////////////
  initial
  begin
    logic [7:0] d, lu, ll, x, y, b, n;
    logic [11:0] expFade;
    void'($urandom(32'h2BBA));
    {s1, s0} = 2'($urandom);
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk(16'(pinOut), 16'({{6{s1}}, {4{s0}}}));
    chk(16'(pinOeN), 16'h0000);
    i_host.wr(8'h7E, 8'hFF);
    // reset values, plus an unmapped place after a write to it
    foreach (d[i])
    begin
      case (i)
        0: x = 8'h02; 1: x = 8'h03; 2: x = 8'h04; 3: x = 8'h12;
        4: x = 8'h13; 5: x = 8'h14; default: x = 8'h7E;
      endcase
      y = (i == 0) ? {2'h0, {6{s1}}} : (i == 1) ? {4'h0, {4{s0}}} : (i == 3) ? 8'h3F : (i == 4) ? 8'h0F : 8'h00;
      i_host.rd(x, n);
      chk(16'(n), 16'(y));
    end
    // gpio use: levels and directions from random writes
    repeat (8)
    begin
      {lu, ll, x, y} = $urandom;
      i_host.wr(8'h02, lu);
      i_host.wr(8'h03, ll);
      i_host.wr(8'h04, x);
      i_host.wr(8'h05, y);
      @(negedge mclk);
      chk(16'(pinOut), 16'({lu[5:0], ll[3:0]}));
      chk(16'(pinOeN), 16'({x[5:0], y[3:0]}));
      i_host.rd(8'h02, d);
      chk(16'(d), 16'({2'h0, lu[5:0]}));
    end
    // led use with breathing on some channels; zero, four and five always on, two left off
    b = (8'($urandom) | 8'h31) & 8'hFB;
    i_host.wr(8'h14, b);
    i_host.wr(8'h12, 8'hC0);
    i_host.wr(8'h13, 8'hF0);
    @(negedge mclk);
    chk(16'(ledMode), 16'h03FF);
    chk(16'(pinOut), 16'h0000);
    chk(16'(pinOeN), 16'h03FF);
    chk(16'(flashSel), 16'({x[1:0], y[3:0]} & b[5:0]));
    // the start bit must leave the selected effect alone
    i_host.start_flash();
    @(negedge mclk);
    chk(16'(flashSel), 16'({x[1:0], y[3:0]} & b[5:0]));
    for (int i = 0; i < 10; i++)
    begin
      n = (i == 2) ? ll : 8'($urandom);
      if (i % 2 == 0)
      begin
        expFade = fade_exp({lu[1:0], ll[3:0]}, {lu[1:0], n[3:0]}, b[5:0]);
        ll = n;
      end
      else
      begin
        expFade = fade_exp({lu[1:0], ll[3:0]}, {n[1:0], ll[3:0]}, b[5:0]);
        lu = n;
      end
      i_host.wr((i % 2 == 0) ? 8'h03 : 8'h02, n);
      // the pulse stands only in the cycle right after the write edge
      chk(16'(fade), 16'(expFade));
      @(negedge mclk);
      chk(16'(fade), 16'h0000);
    end
    end_sim();
  end
endmodule // lgoc_gpio_ctrl_tb_top
